//--- rtl/ccor_regs.sv
// Top: serial slave holding the charger option and charge current registers.
`timescale 1ns/10ps
`include "ccor_consts.svh"
module ccor_regs
   import ccor_pkg::*;
(
   input  wire logic       sys_clk_in,
   input  wire logic       rst_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic       depletion_reached_in,
   input  wire logic [6:0] current_cap_code_in,
   output logic            sda_out,
   output logic            sda_oe_out,
   output logic [1:0]      depletion_sel_out,
   output ccor_ctrl_s      ctrl_out,
   output logic            adapter_switch_on_out,
   output logic            battery_switch_on_out,
   output logic            current_monitor_sel_out,
   output logic [6:0]      charge_current_code_out,
   output logic [6:0]      effective_current_code_out,
   output logic            charge_enable_out
);
   ccor_state_e state_ff;
   logic [15:0] option_ff;
   logic [15:0] current_ff;
   logic [7:0]  cmd_ff;
   logic [7:0]  low_ff;
   logic        rd_ff;
   logic        start_p;
   logic        stop_p;
   logic        byte_p;
   logic [7:0]  rx_byte;
   logic        master_ack;
   logic        ack;
   logic        ack_ff;
   logic        tx_mode;
   logic [15:0] rd_word;
   logic [7:0]  tx_byte;
   logic        known_cmd;
   logic        word_done;
   logic [15:0] wr_word;
   logic [6:0]  wr_code;

   // -----------------------------------------------------------------
   // Byte framing
   // -----------------------------------------------------------------
   // Shifter instance; SDA only ever pulls low.
   ccor_bytes u_bytes (
      .sys_clk_in     (sys_clk_in),
      .rst_in         (rst_in),
      .scl_in         (scl_in),
      .sda_in         (sda_in),
      .ack_in         (ack_ff),
      .tx_byte_in     (tx_byte),
      .tx_mode_in     (tx_mode),
      .start_out      (start_p),
      .stop_out       (stop_p),
      .byte_out       (byte_p),
      .rx_byte_out    (rx_byte),
      .master_ack_out (master_ack),
      .sda_oe_out     (sda_oe_out)
   );
   assign sda_out = 1'b0;

   // Our address, known commands and the two write data bytes after them are acknowledged.
   assign known_cmd = (rx_byte == `CCOR_CMD_OPTION) || (rx_byte == `CCOR_CMD_CURRENT);
   always_comb begin
      case (state_ff)
         CCOR_ADDR: ack = (rx_byte[7:1] == `CCOR_SLAVE_ADDR);
         CCOR_CMD:  ack = known_cmd;
         CCOR_LOW:  ack = 1'b1;
         CCOR_HIGH: ack = 1'b1;
         default:   ack = 1'b0;
      endcase
   end
   // The answer for the byte just taken is latched on the same edge that moves the state on.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in || start_p || stop_p) begin
         ack_ff <= 1'b0;
      end else if (byte_p) begin
         ack_ff <= ack;                                 // R17
      end
   end
   assign tx_mode = (state_ff == CCOR_RLOW) || (state_ff == CCOR_RHIGH);
   assign rd_word = (cmd_ff == `CCOR_CMD_OPTION) ? option_ff : current_ff;
   // The byte for the next slot is chosen after the preceding acknowledge.
   assign tx_byte = (state_ff == CCOR_RLOW) ? rd_word[7:0] : rd_word[15:8];

   // -----------------------------------------------------------------
   // Transfer sequencer
   // -----------------------------------------------------------------
   // Address, command, low byte, high byte; a repeated start turns to read.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in || stop_p) begin
         state_ff <= CCOR_IDLE;
         cmd_ff   <= 8'h00;
         low_ff   <= 8'h00;
         rd_ff    <= 1'b0;
      end else if (start_p) begin
         state_ff <= CCOR_ADDR;                         // R16
      end else if (byte_p) begin
         case (state_ff)
            CCOR_ADDR: begin
               rd_ff <= rx_byte[0];
               if (rx_byte[7:1] != `CCOR_SLAVE_ADDR) begin
                  state_ff <= CCOR_SKIP;
               end else if (rx_byte[0]) begin
                  state_ff <= CCOR_RLOW;
               end else begin
                  state_ff <= CCOR_CMD;
               end
            end
            CCOR_CMD: begin
               cmd_ff   <= rx_byte;
               state_ff <= known_cmd ? CCOR_LOW : CCOR_SKIP;
            end
            CCOR_LOW: begin
               low_ff   <= rx_byte;                     // R19
               state_ff <= CCOR_HIGH;
            end
            CCOR_HIGH:  state_ff <= CCOR_SKIP;
            CCOR_RLOW:  state_ff <= CCOR_RHIGH;
            CCOR_RHIGH: state_ff <= CCOR_SKIP;
            default:    state_ff <= state_ff;
         endcase
      end
   end

   // Write completes only once the high byte has been taken in.
   assign word_done = byte_p && (state_ff == CCOR_HIGH) && !start_p && !stop_p;   // R19
   assign wr_word   = {rx_byte, low_ff};
   assign wr_code   = wr_word[12:6];                     // R13

   // -----------------------------------------------------------------
   // Option register
   // -----------------------------------------------------------------
   // Learn bit falls by itself once the battery reaches depletion level.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         option_ff <= `CCOR_OPT_RESET;                  // R1 R2 R3 R7 R8 R9
      end else if (word_done && cmd_ff == `CCOR_CMD_OPTION) begin
         option_ff <= wr_word & `CCOR_OPT_MASK;         // R18 R4 R6
      end else if (option_ff[`CCOR_OPT_LEARN] && depletion_reached_in) begin
         option_ff[`CCOR_OPT_LEARN] <= 1'b0;            // R5
      end
   end

   // -----------------------------------------------------------------
   // Charge current register
   // -----------------------------------------------------------------
   // An out of range code clears the setting, which stops charging.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         current_ff <= `CCOR_CUR_RESET;                 // R12
      end else if (word_done && cmd_ff == `CCOR_CMD_CURRENT) begin
         if (wr_code < `CCOR_CUR_MIN_CODE || wr_code > `CCOR_CUR_MAX_CODE) begin
            current_ff <= 16'h0000;                     // R11
         end else begin
            current_ff <= wr_word & `CCOR_CUR_MASK;     // R10 R18
         end
      end
   end

   // -----------------------------------------------------------------
   // Control outputs
   // -----------------------------------------------------------------
   // Option fields are fanned out to the analog section.
   always_comb begin
      ctrl_out.freq_up         = option_ff[`CCOR_OPT_FREQ_UP];            // R1
      ctrl_out.freq_en         = option_ff[`CCOR_OPT_FREQ_EN];            // R2
      ctrl_out.short_sel       = option_ff[`CCOR_OPT_SHORT_LO +: 2];      // R3
      ctrl_out.learn_active    = option_ff[`CCOR_OPT_LEARN];
      ctrl_out.mon_charge      = option_ff[`CCOR_OPT_MON_SEL];            // R7
      ctrl_out.overcurrent_sel = option_ff[`CCOR_OPT_OC_LO +: 2];         // R8
      ctrl_out.inhibit         = option_ff[`CCOR_OPT_INHIBIT];            // R9
   end
   assign depletion_sel_out       = 2'h3;
   assign current_monitor_sel_out = option_ff[`CCOR_OPT_MON_SEL];         // R7
   // Learn swaps the system supply from adapter to battery.
   assign battery_switch_on_out   = option_ff[`CCOR_OPT_LEARN];           // R4 R5 R6
   assign adapter_switch_on_out   = ~option_ff[`CCOR_OPT_LEARN];          // R4 R5 R6
   assign charge_current_code_out = current_ff[`CCOR_CUR_LSB +: 7];       // R13
   // Cap pin code bounds the setting; a high cap code disables the bound.
   assign effective_current_code_out =
      (current_cap_code_in < charge_current_code_out) ?
      current_cap_code_in : charge_current_code_out;                      // R14 R15
   assign charge_enable_out = ~option_ff[`CCOR_OPT_INHIBIT] &&
                              (charge_current_code_out != 7'h00);         // R9 R11
endmodule

//--- rtl/ccor_consts.svh
// Constants for the charger option and charge current register bank.
// How it works
// R1: Bit 10 picks frequency shift down or up.
// R2: Bit 9 enables the frequency shift.
// R3: Bits 8:7 pick high side short threshold.
// R4: Writing learn bit starts battery discharge cycle.
// R5: Depletion reached ends learn, clears bit itself.
// R6: Writing learn zero stops cycle, adapter on.
// R7: Bit 5 picks current monitor source.
// R8: Bits 2:1 set input overcurrent trip level.
// R9: Bit 0 inhibits charging, resets permitting.
// R10: Charge current word at command 0x14.
// R11: Out of range value clears register, stops.
// R12: Charge current setting resets to zero.
// R13: Code sits in bits 12:6, 64mA per step.
// R14: Effective limit is smaller of register, cap.
// R15: Host drives cap pin high to disable it.
// R16: Address, command, then data between start, stop.
// R17: Nine clocks per byte, ninth acknowledges.
// R18: Unused bits ignore writes and read zero.
// R19: Word takes effect after both bytes, low first.
`ifndef CCOR_CONSTS_SVH
`define CCOR_CONSTS_SVH
`define CCOR_CMD_OPTION     8'h12
`define CCOR_CMD_CURRENT    8'h14
`define CCOR_SLAVE_ADDR     7'h09
`define CCOR_OPT_MASK       16'h07E7
`define CCOR_OPT_RESET      16'h0104
`define CCOR_OPT_INHIBIT    0
`define CCOR_OPT_OC_LO      1
`define CCOR_OPT_MON_SEL    5
`define CCOR_OPT_LEARN      6
`define CCOR_OPT_SHORT_LO   7
`define CCOR_OPT_FREQ_EN    9
`define CCOR_OPT_FREQ_UP    10
`define CCOR_CUR_MASK       16'h1FC0
`define CCOR_CUR_RESET      16'h0000
`define CCOR_CUR_LSB        6
`define CCOR_CUR_MIN_CODE   7'h02
`define CCOR_CUR_MAX_CODE   7'h7F
`endif

//--- rtl/ccor_pkg.sv
// Types shared by the charger option and charge current register bank.
package ccor_pkg;
   typedef enum logic [3:0] {
      CCOR_IDLE  = 4'b0000,
      CCOR_ADDR  = 4'b0001,
      CCOR_CMD   = 4'b0010,
      CCOR_LOW   = 4'b0011,
      CCOR_HIGH  = 4'b0100,
      CCOR_RLOW  = 4'b0101,
      CCOR_RHIGH = 4'b0110,
      CCOR_SKIP  = 4'b0111
   } ccor_state_e;
   typedef struct packed {
      logic       freq_up;
      logic       freq_en;
      logic [1:0] short_sel;
      logic       learn_active;
      logic       mon_charge;
      logic [1:0] overcurrent_sel;
      logic       inhibit;
   } ccor_ctrl_s;
endpackage

//--- rtl/ccor_bytes.sv
// Serial byte shifter: start, stop, nine clock byte framing and acknowledge drive.
`timescale 1ns/10ps
`include "ccor_consts.svh"
module ccor_bytes
   import ccor_pkg::*;
(
   input  wire logic       sys_clk_in,
   input  wire logic       rst_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic       ack_in,
   input  wire logic [7:0] tx_byte_in,
   input  wire logic       tx_mode_in,
   output logic            start_out,
   output logic            stop_out,
   output logic            byte_out,
   output logic [7:0]      rx_byte_out,
   output logic            master_ack_out,
   output logic            sda_oe_out
);
   logic [1:0] scl_sync_ff;
   logic [1:0] sda_sync_ff;
   logic       scl_ff;
   logic       sda_ff;
   logic [3:0] bit_cnt_ff;
   logic [7:0] shift_ff;
   logic [7:0] tx_ff;
   logic       ack_slot_ff;
   logic       scl_rise;
   logic       scl_fall;

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   // Two stages before any logic looks at the pins.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         scl_sync_ff <= 2'h3;
         sda_sync_ff <= 2'h3;
         scl_ff      <= 1'b1;
         sda_ff      <= 1'b1;
      end else begin
         scl_sync_ff <= {scl_sync_ff[0], scl_in};
         sda_sync_ff <= {sda_sync_ff[0], sda_in};
         scl_ff      <= scl_sync_ff[1];
         sda_ff      <= sda_sync_ff[1];
      end
   end

   assign scl_rise  = scl_sync_ff[1] & ~scl_ff;
   assign scl_fall  = ~scl_sync_ff[1] & scl_ff;
   assign start_out = scl_sync_ff[1] & scl_ff & sda_ff & ~sda_sync_ff[1];   // R16
   assign stop_out  = scl_sync_ff[1] & scl_ff & ~sda_ff & sda_sync_ff[1];   // R16

   // -----------------------------------------------------------------
   // Bit counter and shifter
   // -----------------------------------------------------------------
   // Eight data bits then the ninth acknowledge clock per byte.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in || start_out || stop_out) begin
         bit_cnt_ff     <= 4'h0;
         shift_ff       <= 8'h00;
         rx_byte_out    <= 8'h00;
         byte_out       <= 1'b0;
         master_ack_out <= 1'b0;
      end else begin
         byte_out <= 1'b0;
         if (scl_rise) begin
            if (bit_cnt_ff == 4'h8) begin
               bit_cnt_ff     <= 4'h0;                  // R17
               master_ack_out <= ~sda_sync_ff[1];
            end else begin
               shift_ff   <= {shift_ff[6:0], sda_sync_ff[1]};
               bit_cnt_ff <= bit_cnt_ff + 4'h1;
               if (bit_cnt_ff == 4'h7) begin
                  rx_byte_out <= {shift_ff[6:0], sda_sync_ff[1]};
                  byte_out    <= 1'b1;
               end
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Data line drive
   // -----------------------------------------------------------------
   // Pulls the line low for an acknowledge or a zero read bit, on SCL low.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in || start_out || stop_out) begin
         tx_ff        <= 8'hFF;
         ack_slot_ff  <= 1'b0;
         sda_oe_out   <= 1'b0;
      end else if (scl_fall) begin
         if (bit_cnt_ff == 4'h8) begin
            // The read address is acknowledged although transmit mode is already set.
            ack_slot_ff  <= 1'b1;
            sda_oe_out   <= ack_in;                     // R17
         end else begin
            if (ack_slot_ff) begin
               tx_ff      <= {tx_byte_in[6:0], 1'b1};
               sda_oe_out <= tx_mode_in & ~tx_byte_in[7];
            end else begin
               tx_ff      <= {tx_ff[6:0], 1'b1};
               sda_oe_out <= tx_mode_in & (bit_cnt_ff != 4'h0) & ~tx_ff[7];
            end
            ack_slot_ff  <= 1'b0;
         end
      end
   end
endmodule

//--- verif/ccor_regs_asserts.sv
// Port-level checker for the charger option and charge current register bank.
`timescale 1ns/10ps
module ccor_regs_asserts
   import ccor_pkg::*;
(
   input wire logic       sys_clk_in,
   input wire logic       rst_in,
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       depletion_reached_in,
   input wire logic [6:0] current_cap_code_in,
   input wire logic       sda_out,
   input wire logic       sda_oe_out,
   input wire logic [1:0] depletion_sel_out,
   input wire ccor_ctrl_s ctrl_out,
   input wire logic       adapter_switch_on_out,
   input wire logic       battery_switch_on_out,
   input wire logic       current_monitor_sel_out,
   input wire logic [6:0] charge_current_code_out,
   input wire logic [6:0] effective_current_code_out,
   input wire logic       charge_enable_out
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);
   // Register fields and derived outputs tied to their sources.
   a_reset_state: assert property ($fell(rst_in) |->
      ctrl_out == 9'h044 && charge_current_code_out == 7'h00) else $error("bad reset state");
   a_switch_pair: assert property (battery_switch_on_out == ctrl_out.learn_active &&
      adapter_switch_on_out == !battery_switch_on_out) else $error("switch pair wrong");
   a_monitor_sel: assert property (current_monitor_sel_out == ctrl_out.mon_charge)
      else $error("monitor source wrong");
   a_eff_min: assert property (effective_current_code_out ==
      ((charge_current_code_out < current_cap_code_in) ? charge_current_code_out
      : current_cap_code_in)) else $error("effective limit not the minimum");
   a_charge_enable: assert property (charge_enable_out ==
      (!ctrl_out.inhibit && charge_current_code_out != 7'h00)) else $error("charge enable wrong");
   a_code_range: assert property (charge_current_code_out != 7'h01)
      else $error("out of range code held");
   a_learn_clear: assert property (ctrl_out.learn_active && depletion_reached_in |->
      ##[1:4] !ctrl_out.learn_active) else $error("learn not cleared");
   a_ack_stable: assert property (!$stable(sda_oe_out) |-> !scl_in)
      else $error("data drive changed while clock high");
   // Main scenarios reached.
   c_learn_end: cover property ($fell(ctrl_out.learn_active));
   c_ack: cover property ($rose(sda_oe_out));
   c_charging: cover property ($rose(charge_enable_out));
endmodule
bind ccor_regs ccor_regs_asserts u_chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
   .scl_in(scl_in), .sda_in(sda_in), .depletion_reached_in(depletion_reached_in),
   .current_cap_code_in(current_cap_code_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
   .depletion_sel_out(depletion_sel_out), .ctrl_out(ctrl_out),
   .adapter_switch_on_out(adapter_switch_on_out),
   .battery_switch_on_out(battery_switch_on_out),
   .current_monitor_sel_out(current_monitor_sel_out),
   .charge_current_code_out(charge_current_code_out),
   .effective_current_code_out(effective_current_code_out),
   .charge_enable_out(charge_enable_out));

//--- verif/ccor_host.sv
// Host model that drives the serial pins with word transfers.
`timescale 1ns/10ps
`include "ccor_consts.svh"
module ccor_host (
   input  wire logic clk_in,
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_out
);
   localparam int HALF = 10;
   // Both lines start released so the pull-up holds them high.
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // Pins move only at falling system clock edges.
   task automatic pause(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   // Start or repeated start: data falls while the clock is high.
   task automatic start();
      pause(2);
      sda_out = 1'b1;
      pause(HALF);
      scl_out = 1'b1;
      pause(HALF);
      sda_out = 1'b0;
      pause(HALF);
      scl_out = 1'b0;
   endtask
   // Stop: data rises while the clock is high.
   task automatic stop();
      pause(2);
      sda_out = 1'b0;
      pause(HALF);
      scl_out = 1'b1;
      pause(HALF);
      sda_out = 1'b1;
      pause(HALF);
   endtask
   // One clock: data set while low, the wire sampled while high.
   task automatic bit_x(input logic b, output logic r);
      pause(2);
      sda_out = b;
      pause(HALF);
      scl_out = 1'b1;
      pause(HALF);
      r = sda_in;
      scl_out = 1'b0;
   endtask
   // Nine clocks a byte, most significant bit first, acknowledge on the ninth.
   task automatic byte_x(input logic [7:0] b, input logic a, output logic [7:0] r,
                         output logic ar);
      for (int i = 7; i >= 0; i--) begin
         bit_x(b[i], r[i]);
      end
      bit_x(a, ar);
   endtask
   // Word write; nb limits the data bytes sent, low byte first.
   task automatic write_word(input logic [6:0] adr, input logic [7:0] cmd,
                             input logic [15:0] d, input int nb, output logic [3:0] ak);
      logic [7:0] r;
      ak = 4'hF;
      start();
      byte_x({adr, 1'b0}, 1'b1, r, ak[3]);
      byte_x(cmd, 1'b1, r, ak[2]);
      if (nb > 0) byte_x(d[7:0], 1'b1, r, ak[1]);
      if (nb > 1) byte_x(d[15:8], 1'b1, r, ak[0]);
      stop();
   endtask
   // Word read with repeated start, NACK on the high byte.
   task automatic read_word(input logic [7:0] cmd, output logic [15:0] d,
                            output logic [3:0] ak);
      logic [7:0] r;
      logic       x;
      ak = 4'h0;
      start();
      byte_x({`CCOR_SLAVE_ADDR, 1'b0}, 1'b1, r, ak[3]);
      byte_x(cmd, 1'b1, r, ak[2]);
      start();
      byte_x({`CCOR_SLAVE_ADDR, 1'b1}, 1'b1, r, ak[1]);
      byte_x(8'hFF, 1'b0, d[7:0], x);
      byte_x(8'hFF, 1'b1, d[15:8], x);
      stop();
   endtask
endmodule

//--- verif/tb_ccor_regs.sv
// Self-checking bench for the charger option and charge current register bank.
`timescale 1ns/10ps
`include "ccor_consts.svh"
module tb_ccor_regs;
   logic                 sys_clk;
   logic                 rst;
   logic                 depl;
   logic [6:0]           cap;
   logic                 scl;
   logic                 host_sda;
   wire logic            sda_w;
   logic                 sda_oe;
   logic                 sda_o;
   logic                 adapter_on;
   logic                 battery_on;
   logic                 mon_sel;
   logic [6:0]           code;
   logic [6:0]           eff;
   logic                 chg_en;
   logic [1:0]           dsel;
   ccor_pkg::ccor_ctrl_s ctrl;
   int                   n_mismatch = 0;
   int                   samples_checked = 0;
   // Open-drain data wire with a pull-up.
   assign sda_w = host_sda & ~(sda_oe & ~sda_o);
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   ccor_regs dut (.sys_clk_in(sys_clk), .rst_in(rst), .scl_in(scl), .sda_in(sda_w),
      .depletion_reached_in(depl), .current_cap_code_in(cap), .sda_out(sda_o),
      .sda_oe_out(sda_oe), .depletion_sel_out(dsel), .ctrl_out(ctrl),
      .adapter_switch_on_out(adapter_on), .battery_switch_on_out(battery_on),
      .current_monitor_sel_out(mon_sel), .charge_current_code_out(code),
      .effective_current_code_out(eff), .charge_enable_out(chg_en));
   ccor_host host (.clk_in(sys_clk), .sda_in(sda_w), .scl_out(scl), .sda_out(host_sda));
   //----------------------------------------------------------------
   // Shared checks and transfers
   //----------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
      logic [3:0] ak;
      host.write_word(`CCOR_SLAVE_ADDR, cmd, d, 2, ak);
      chk(16'(ak), 16'h0000);
   endtask
   task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
      logic [3:0]  ak;
      logic [15:0] d;
      host.read_word(cmd, d, ak);
      chk(16'(ak), 16'h0000);
      chk(d, exp);
   endtask
   task automatic t_reset();
      rd(`CCOR_CMD_OPTION, 16'h0104);
      rd(`CCOR_CMD_CURRENT, 16'h0000);
      chk(16'(dsel), 16'h0003);
      chk(16'({chg_en, battery_on, adapter_on}), 16'h0001);
   endtask
   task automatic t_option();
      logic [15:0] d;
      wr(`CCOR_CMD_OPTION, 16'hFFFF);
      rd(`CCOR_CMD_OPTION, 16'h07E7);
      chk(16'(ctrl), 16'h01FF);
      chk(16'({mon_sel, battery_on, adapter_on}), 16'h0006);
      for (int k = 0; k < 4; k++) begin
         d = 16'((k << 1) | (k << 7) | (k << 9));
         wr(`CCOR_CMD_OPTION, d);
         chk(16'(ctrl), {7'h00, d[10:7], 2'b00, d[2:0]});
      end
      chk(16'({battery_on, adapter_on}), 16'h0001);
      wr(`CCOR_CMD_OPTION, 16'h0000);
   endtask
   task automatic t_learn();
      wr(`CCOR_CMD_OPTION, 16'h0040);
      chk(16'({battery_on, adapter_on}), 16'h0002);
      depl = 1'b1;
      repeat (6) @(negedge sys_clk);
      chk(16'({battery_on, adapter_on}), 16'h0001);
      depl = 1'b0;
      rd(`CCOR_CMD_OPTION, 16'h0000);
   endtask
   task automatic t_current();
      wr(`CCOR_CMD_CURRENT, 16'hFFFF);
      rd(`CCOR_CMD_CURRENT, 16'h1FC0);
      chk(16'(code), 16'h007F);
      cap = 7'h10;
      @(negedge sys_clk);
      chk(16'(eff), 16'h0010);
      wr(`CCOR_CMD_CURRENT, 16'h0040);
      rd(`CCOR_CMD_CURRENT, 16'h0000);
      chk(16'(chg_en), 16'h0000);
      wr(`CCOR_CMD_CURRENT, 16'h0080);
      chk(16'({chg_en, eff}), 16'h0082);
      cap = 7'h7F;
      wr(`CCOR_CMD_OPTION, 16'h0001);
      chk(16'({chg_en, eff}), 16'h0002);
      wr(`CCOR_CMD_OPTION, 16'h0000);
   endtask
   task automatic t_refuse();
      logic [3:0] ak;
      host.write_word(7'h0A, `CCOR_CMD_CURRENT, 16'h1234, 2, ak);
      chk(16'(ak), 16'h000F);
      host.write_word(`CCOR_SLAVE_ADDR, 8'h15, 16'h1234, 2, ak);
      chk(16'(ak), 16'h0007);
      host.write_word(`CCOR_SLAVE_ADDR, `CCOR_CMD_CURRENT, 16'h0100, 1, ak);
      chk(16'(ak), 16'h0001);
      rd(`CCOR_CMD_CURRENT, 16'h0080);
   endtask
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (60000) @(posedge sys_clk);
      n_mismatch++;
      print_verdict();
   end
   // Main sequence: reset, then each scenario in turn.
   initial begin
      rst = 1'b1;
      depl = 1'b0;
      cap = 7'h7F;
      repeat (8) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      t_reset();
      t_option();
      t_learn();
      t_current();
      t_refuse();
      print_verdict();
   end
endmodule
